// >>> hw/bridge_window_config_regs.v
// upper window, capability pointer and interrupt byte registers of the bridge config space
// assumes config cycles arrive already decoded to a dword-aligned byte offset on the primary clock;
// lower window halves other than the prefetch limit field come from the neighbouring config block
// forward decisions leave on flops, one cycle behind the address
`timescale 1ns/1ns
`include "bridge_window_consts.vh"
module bridge_window_config_regs (
   input  wire        clk_sys,         // primary clock
   input  wire        resetn,          // async reset, active low
   input  wire        cfg_wr,          // config write strobe, one cycle
   input  wire        cfg_rd,          // config read strobe, one cycle
   input  wire [7:0]  cfg_addr,        // config byte offset, dword aligned
   input  wire [3:0]  cfg_be,          // byte enables of write
   input  wire [31:0] cfg_wdata,       // write data
   output wire [31:0] cfg_rdata,       // read data, valid with cfg_rvalid
   output wire        cfg_rvalid,      // read answer, one cycle pulse
   input  wire [11:0] pf_base_low,     // prefetch base address 31:20
   input  wire [15:0] io_base_low,     // I/O base address 15:0
   input  wire [15:0] io_limit_low,    // I/O limit address 15:0
   input  wire [63:0] mem_addr,        // memory transaction address
   input  wire [31:0] io_addr,         // I/O transaction address
   output wire        mem_forward,     // memory address falls in prefetch window
   output wire        io_forward       // I/O address falls in I/O window
);

   reg  [11:0] pf_limit_ff;
   reg  [31:0] pf_base_upper_ff;
   reg  [31:0] pf_limit_upper_ff;
   reg  [15:0] io_base_upper_ff;
   reg  [15:0] io_limit_upper_ff;
   reg  [7:0]  int_line_ff;
   reg  [31:0] rdata_ff;
   reg  [31:0] nxt_rdata;
   reg         rvalid_ff;
   reg         mem_forward_ff;
   reg         io_forward_ff;

   // bit positions of the one-hot register select
   localparam SEL_PF_LIMIT = 0;
   localparam SEL_PF_BUP   = 1;
   localparam SEL_PF_LUP   = 2;
   localparam SEL_IO_UP    = 3;
   localparam SEL_CAP_PTR  = 4;
   localparam SEL_INT      = 5;

   wire [5:0]  sel;
   wire [5:0]  wr_hit;
   wire        mem_hit;
   wire        io_hit;
   // assembled full-width window edges
   wire [63:0] pf_base_full;
   wire [63:0] pf_limit_full;
   wire [31:0] io_base_full;
   wire [31:0] io_limit_full;

   // merge byte-enabled write data over the old word
   function [31:0] merge;
      input [31:0] old;
      input [31:0] wd;
      input [3:0]  be;
      integer      i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1)
            if (be[i])
               merge[i*8 +: 8] = wd[i*8 +: 8];
      end
   endfunction

   wire [31:0] w_pf_limit = merge({pf_limit_ff, 20'h0_0000}, cfg_wdata, cfg_be);
   wire [31:0] w_pf_bup   = merge(pf_base_upper_ff, cfg_wdata, cfg_be);
   wire [31:0] w_pf_lup   = merge(pf_limit_upper_ff, cfg_wdata, cfg_be);
   wire [31:0] w_io_up    = merge({io_limit_upper_ff, io_base_upper_ff}, cfg_wdata, cfg_be);
   wire [31:0] w_int      = merge({24'h00_0000, int_line_ff}, cfg_wdata, cfg_be);

   // register decode, shared by the write enables and the read mux
   function [5:0] reg_select;
      input [7:0] ofs;
      begin
         case (ofs)
            `OFS_PF_LIMIT:       reg_select = 6'h01;
            `OFS_PF_BASE_UPPER:  reg_select = 6'h02;
            `OFS_PF_LIMIT_UPPER: reg_select = 6'h04;
            `OFS_IO_UPPER:       reg_select = 6'h08;
            `OFS_CAP_PTR:        reg_select = 6'h10;
            `OFS_INT_LINE_PIN:   reg_select = 6'h20;
            default:             reg_select = 6'h00;
         endcase
      end
   endfunction

   assign sel    = reg_select(cfg_addr);
   assign wr_hit = cfg_wr ? sel : 6'h00;

   // one block per register keeps each reset and write enable easy to audit
   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         pf_limit_ff <= `RST_PF_LIMIT;
      else if (wr_hit[SEL_PF_LIMIT])
         pf_limit_ff <= w_pf_limit[31:`PF_LIMIT_POS];
   end

   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         pf_base_upper_ff <= `RST_UPPER32;
      else if (wr_hit[SEL_PF_BUP])
         pf_base_upper_ff <= w_pf_bup;
   end

   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         pf_limit_upper_ff <= `RST_UPPER32;
      else if (wr_hit[SEL_PF_LUP])
         pf_limit_upper_ff <= w_pf_lup;
   end

   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         io_base_upper_ff <= `RST_UPPER16;
      else if (wr_hit[SEL_IO_UP])
         io_base_upper_ff <= w_io_up[15:0];
   end

   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         io_limit_upper_ff <= `RST_UPPER16;
      else if (wr_hit[SEL_IO_UP])
         io_limit_upper_ff <= w_io_up[31:`IO_LIMIT_POS];
   end

   // pin byte and bridge control half are never stored here
   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         int_line_ff <= `RST_INT_LINE;
      else if (wr_hit[SEL_INT])
         int_line_ff <= w_int[7:0];
   end

   // read words as software sees them; low half of 24h is the base register,
   // owned elsewhere, so it reads zero from this block
   wire [31:0] rd_pf_limit = {pf_limit_ff, `PF_ADDR_CAP_64, 16'h0000};
   wire [31:0] rd_io_up    = {io_limit_upper_ff, io_base_upper_ff};
   wire [31:0] rd_cap_ptr  = {24'h00_0000, `CAP_PTR_VALUE};
   wire [31:0] rd_int      = {16'h0000, `INT_PIN_NONE, int_line_ff};

   always @*
   begin
      case (sel)
         6'h01:   nxt_rdata = rd_pf_limit;
         6'h02:   nxt_rdata = pf_base_upper_ff;
         6'h04:   nxt_rdata = pf_limit_upper_ff;
         6'h08:   nxt_rdata = rd_io_up;
         6'h10:   nxt_rdata = rd_cap_ptr;
         6'h20:   nxt_rdata = rd_int;
         default:             nxt_rdata = 32'h0000_0000;
      endcase
   end

   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         rdata_ff  <= 32'h0000_0000;
         rvalid_ff <= 1'b0;
      end
      else
      begin
         rvalid_ff <= cfg_rd;
         if (cfg_rd)
            rdata_ff <= nxt_rdata;
      end
   end

   // registered so the decisions leave on clean flop outputs
   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         mem_forward_ff <= 1'h0;
      else
         mem_forward_ff <= mem_hit;
   end

   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         io_forward_ff <= 1'h0;
      else
         io_forward_ff <= io_hit;
   end

   assign cfg_rdata   = rdata_ff;
   assign cfg_rvalid  = rvalid_ff;
   assign mem_forward = mem_forward_ff;
   assign io_forward  = io_forward_ff;

   assign pf_base_full  = {pf_base_upper_ff, pf_base_low, 20'h0_0000};
   assign pf_limit_full = {pf_limit_upper_ff, pf_limit_ff, `PF_LIMIT_LOW_ONES};
   assign io_base_full  = {io_base_upper_ff, io_base_low};
   assign io_limit_full = {io_limit_upper_ff, io_limit_low};

   window_match #(
      .AW(64)
   ) u_pf_match (
      .addr  (mem_addr),
      .base  (pf_base_full),
      .limit (pf_limit_full),
      .hit   (mem_hit)
   );

   window_match #(
      .AW(32)
   ) u_io_match (
      .addr  (io_addr),
      .base  (io_base_full),
      .limit (io_limit_full),
      .hit   (io_hit)
   );

endmodule // bridge_window_config_regs

// >>> hw/bridge_window_consts.vh
// offsets, field positions, reset values and fixed codes of the window config registers
// assumes byte offsets into a dword-aligned configuration space
`ifndef BRIDGE_WINDOW_CONSTS_VH
`define BRIDGE_WINDOW_CONSTS_VH

`define OFS_PF_LIMIT       8'h24
`define OFS_PF_BASE_UPPER  8'h28
`define OFS_PF_LIMIT_UPPER 8'h2C
`define OFS_IO_UPPER       8'h30
`define OFS_CAP_PTR        8'h34
`define OFS_INT_LINE_PIN   8'h3C

`define PF_ADDR_CAP_POS    16
`define PF_ADDR_CAP_64     4'h1
`define PF_LIMIT_POS       20
`define PF_LIMIT_LOW_ONES  20'hF_FFFF
`define IO_LIMIT_POS       16
`define INT_PIN_POS        8
`define INT_PIN_NONE       8'h00
`define CAP_PTR_VALUE      8'hDC

`define RST_PF_LIMIT       12'h000
`define RST_UPPER32        32'h0000_0000
`define RST_UPPER16        16'h0000
`define RST_INT_LINE       8'h00

`endif

// >>> hw/window_match.v
// inclusive address window compare
// assumes base and limit are full-width addresses already assembled by the caller
`timescale 1ns/1ns
module window_match #(
   parameter AW = 32
) (
   input  wire [AW-1:0] addr,       // address under test
   input  wire [AW-1:0] base,       // lowest address inside window
   input  wire [AW-1:0] limit,      // highest address inside window
   output wire          hit         // address inside window
);

   assign hit = (addr >= base) && (addr <= limit);

endmodule // window_match

// >>> tb/bwc_asserts.sv
// port-level checks of the window config registers
// assumes only the top module's ports; bound after the module
`timescale 1ns/1ns
module bwc_asserts (
   input wire        clk_sys, resetn, cfg_wr, cfg_rd, cfg_rvalid, // watched ports
   input wire [7:0]  cfg_addr,                                     // byte offset
   input wire [3:0]  cfg_be,                                       // lanes
   input wire [31:0] cfg_wdata, cfg_rdata                          // data
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   sequence wr_rd(bit [7:0] a);
      cfg_wr && cfg_be == 4'hf && cfg_addr == a ##1 cfg_rd && cfg_addr == a;
   endsequence
   AST_RD_ANSWER: assert property (cfg_rd |=> cfg_rvalid)
      else $error("read not answered");
   AST_CAP_PTR: assert property (cfg_rd && cfg_addr == 8'h34 |=> cfg_rdata == 32'h0000_00dc)
      else $error("capability pointer wrong");
   AST_ADDR_CAP: assert property (cfg_rd && cfg_addr == 8'h24 |=> cfg_rdata[19:0] == 20'h1_0000)
      else $error("limit low half wrong");
   AST_PIN_NONE: assert property (cfg_rd && cfg_addr == 8'h3c |=> cfg_rdata[31:8] == 24'h00_0000)
      else $error("pin byte not zero");
   AST_BASE_UP: assert property (wr_rd(8'h28) |=> cfg_rdata == $past(cfg_wdata, 2))
      else $error("base upper not stored");
   AST_LIMIT_UP: assert property (wr_rd(8'h2c) |=> cfg_rdata == $past(cfg_wdata, 2))
      else $error("limit upper not stored");
   AST_IO_UP: assert property (wr_rd(8'h30) |=> cfg_rdata == $past(cfg_wdata, 2))
      else $error("io upper not stored");
   AST_LIMIT12: assert property (wr_rd(8'h24) |=> cfg_rdata[31:20] == $past(cfg_wdata[31:20], 2))
      else $error("limit field not stored");
   AST_INT_LINE: assert property (wr_rd(8'h3c) |=> cfg_rdata[7:0] == $past(cfg_wdata[7:0], 2))
      else $error("interrupt line not stored");
   cover property (wr_rd(8'h28));
   cover property (wr_rd(8'h3c));
   cover property (cfg_rd && cfg_addr == 8'h34);
endmodule // bwc_asserts
bind bridge_window_config_regs bwc_asserts i_chk (.*);

// >>> tb/cfg_host.sv
// host config software model issuing one config cycle per call
// assumes the bench clock; changes the bus at the falling edge
`timescale 1ns/1ns
module cfg_host (
   input wire        clk_sys,         // primary clock
   output reg        cfg_wr, cfg_rd,  // strobes
   output reg [7:0]  cfg_addr,        // byte offset
   output reg [3:0]  cfg_be,          // byte lanes
   output reg [31:0] cfg_wdata        // write data
);
   initial {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = '0;
   task cyc(input w, input [7:0] a, input [3:0] b, input [31:0] d);
      begin
         @(negedge clk_sys);
         {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = {w, !w, a, b, d};
      end
   endtask
   // strobes stay up after cyc, so a following cyc runs back to back
   task idle;
      begin
         @(negedge clk_sys);
         cfg_wr = 1'b0;
         cfg_rd = 1'b0;
      end
   endtask
endmodule // cfg_host

// >>> tb/bridge_window_config_regs_bench.sv
// self-checking bench of the window config registers
// assumes cfg_host drives config cycles and the checker is bound to the top
`timescale 1ns/1ns
module bridge_window_config_regs_bench;
   reg         clk_sys = 0, resetn = 0;
   reg [11:0]  pf_base_low = 12'h000;
   reg [15:0]  io_base_low = 16'h1000, io_limit_low = 16'h2000;
   reg [63:0]  mem_addr = 0;
   reg [31:0]  io_addr = 0;
   wire        cfg_wr, cfg_rd, cfg_rvalid, mem_forward, io_forward;
   wire [7:0]  cfg_addr;
   wire [3:0]  cfg_be;
   wire [31:0] cfg_wdata, cfg_rdata;
   integer     fail_count = 0, num_checks = 0, i;
   logic [75:0] rows [8] = '{ // offset, lanes, write data, read back
      {8'h28, 4'hf, 32'h1234_5678, 32'h1234_5678},
      {8'h2c, 4'hf, 32'h9abc_def0, 32'h9abc_def0},
      {8'h30, 4'hf, 32'hffff_0001, 32'hffff_0001},
      {8'h24, 4'hf, 32'hffff_ffff, 32'hfff1_0000},
      {8'h34, 4'hf, 32'hffff_ffff, 32'h0000_00dc},
      {8'h3c, 4'hf, 32'hffff_ffff, 32'h0000_00ff},
      {8'h38, 4'hf, 32'hffff_ffff, 32'h0000_0000},
      {8'h28, 4'h2, 32'h0000_ab00, 32'h1234_ab78}};
   always #4 clk_sys = ~clk_sys;
   cfg_host i_host (.*);
   bridge_window_config_regs i_dut (.*);
   task chk(input [31:0] got, input [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp)
         begin
            fail_count = fail_count + 1;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task rd(input [7:0] a, input [31:0] e);
      begin
         i_host.cyc(1'b0, a, 4'h0, 32'h0000_0000);
         i_host.idle;
         chk(cfg_rdata, e);
         chk({31'h0, cfg_rvalid}, 32'h0000_0001);
      end
   endtask
   task fwd(input [63:0] m, input [31:0] io, input [1:0] e);
      begin
         @(negedge clk_sys);
         mem_addr = m;
         io_addr = io;
         @(negedge clk_sys);
         chk({30'h0, mem_forward, io_forward}, {30'h0, e});
      end
   endtask
   task print_verdict;
      begin
         if (fail_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   initial
   begin
      repeat (3) @(negedge clk_sys);
      resetn = 1;
      rd(8'h28, 32'h0000_0000);
      rd(8'h30, 32'h0000_0000);
      for (i = 0; i < 8; i = i + 1)
      begin
         i_host.cyc(1'b1, rows[i][75:68], rows[i][67:64], rows[i][63:32]);
         rd(rows[i][75:68], rows[i][31:0]);
      end
      fwd(64'h1234_ab78_0000_0000, 32'h0001_1000, 2'b11);
      fwd(64'h1234_ab77_ffff_ffff, 32'h0001_0fff, 2'b00);
      fwd(64'h9abc_def0_ffff_ffff, 32'hffff_2000, 2'b11);
      fwd(64'h9abc_def1_0000_0000, 32'hffff_2001, 2'b00);
      @(negedge clk_sys) resetn = 0;
      @(negedge clk_sys) resetn = 1;
      rd(8'h2c, 32'h0000_0000);
      rd(8'h24, 32'h0001_0000);
      print_verdict;
   end
   initial
   begin
      #20000 fail_count = fail_count + 1;
      print_verdict;
   end
endmodule // bridge_window_config_regs_bench
